// file: rtl/aid_datapath.sv
// Purpose: Arithmetic instruction datapath of an 8-bit controller core
// Assumes: One operation per cycle while op_valid is high; mem_rdata valid with op
// Notes: Memory results leave on mem_wdata with a one-cycle mem_we pulse
`timescale 1ns/1ps
`default_nettype none
module aid_datapath
	import aid_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire logic [aid_pkg::AID_OP_W-1:0] op,
	input wire logic [aid_pkg::AID_DATA_W-1:0] imm,
	input wire logic [aid_pkg::AID_DATA_W-1:0] mem_rdata,
	output logic [aid_pkg::AID_DATA_W-1:0] working_register,
	output logic [aid_pkg::AID_DATA_W-1:0] mem_wdata,
	output logic mem_we,
	output logic result_null_flag,
	output logic arith_out_bit,
	output logic nibble_out_bit,
	output logic signed_wrap_bit
);
	import aid_pkg::*;

	logic [7:0] opa;
	logic [7:0] opb;
	logic cin;
	logic is_sub;
	logic to_mem;
	logic flags_upd;
	logic wr_w;
	logic [7:0] sum;
	logic cout;
	logic hcout;
	logic ovf;
	logic [7:0] res;
	logic [7:0] working_register_d;

	// --------------------------------
	// Operand selection
	// --------------------------------
	// Subtraction is a + ~b + 1 (less borrow); carry out inverts into borrow
	always_comb
	begin
		opa = working_register;
		opb = AID_ZERO;
		cin = 1'b0;
		is_sub = 1'b0;
		to_mem = 1'b0;
		flags_upd = 1'b1;
		wr_w = 1'b0;
		unique case (op)
			AID_OP_ADD_WI:
			begin
				opb = imm;
				wr_w = 1'b1;
			end
			AID_OP_ADD_WM:
			begin
				opb = mem_rdata;
				wr_w = 1'b1;
			end
			AID_OP_ADD_MW:
			begin
				opb = mem_rdata;
				to_mem = 1'b1;
			end
			AID_OP_ADC_WM:
			begin
				opb = mem_rdata;
				cin = arith_out_bit;
				wr_w = 1'b1;
			end
			AID_OP_ADC_MW:
			begin
				opb = mem_rdata;
				cin = arith_out_bit;
				to_mem = 1'b1;
			end
			AID_OP_ADC_W:
			begin
				cin = arith_out_bit;
				wr_w = 1'b1;
			end
			AID_OP_ADC_M:
			begin
				opa = mem_rdata;
				cin = arith_out_bit;
				to_mem = 1'b1;
			end
			AID_OP_NADD_W:
			begin
				opa = mem_rdata;
				opb = ~working_register;
				cin = 1'b1;
				is_sub = 1'b1;
				wr_w = 1'b1;
			end
			AID_OP_NADD_M:
			begin
				opb = ~mem_rdata;
				cin = 1'b1;
				is_sub = 1'b1;
				to_mem = 1'b1;
			end
			AID_OP_SUB_WI:
			begin
				opb = ~imm;
				cin = 1'b1;
				is_sub = 1'b1;
				wr_w = 1'b1;
			end
			AID_OP_SUB_WM:
			begin
				opb = ~mem_rdata;
				cin = 1'b1;
				is_sub = 1'b1;
				wr_w = 1'b1;
			end
			AID_OP_SUB_MW:
			begin
				opa = mem_rdata;
				opb = ~working_register;
				cin = 1'b1;
				is_sub = 1'b1;
				to_mem = 1'b1;
			end
			AID_OP_SBC_WM:
			begin
				opb = ~mem_rdata;
				cin = ~arith_out_bit;
				is_sub = 1'b1;
				wr_w = 1'b1;
			end
			AID_OP_SBC_MW:
			begin
				opa = mem_rdata;
				opb = ~working_register;
				cin = ~arith_out_bit;
				is_sub = 1'b1;
				to_mem = 1'b1;
			end
			AID_OP_SBC_W:
			begin
				opb = ~AID_ZERO;
				cin = ~arith_out_bit;
				is_sub = 1'b1;
				wr_w = 1'b1;
			end
			AID_OP_SBC_M:
			begin
				opa = mem_rdata;
				opb = ~AID_ZERO;
				cin = ~arith_out_bit;
				is_sub = 1'b1;
				to_mem = 1'b1;
			end
			AID_OP_INC_M:
			begin
				opa = mem_rdata;
				opb = AID_ONE;
				to_mem = 1'b1;
			end
			AID_OP_DEC_M:
			begin
				opa = mem_rdata;
				opb = ~AID_ONE;
				cin = 1'b1;
				is_sub = 1'b1;
				to_mem = 1'b1;
			end
			AID_OP_CLR_M:
			begin
				to_mem = 1'b1;
				flags_upd = 1'b0;
			end
			default:
			begin
				flags_upd = 1'b0;
			end
		endcase
	end

	aid_adder #(
		.W(AID_DATA_W)
	) u_adder (
		.a(opa),
		.b(opb),
		.cin(cin),
		.sum(sum),
		.cout(cout),
		.hcout(hcout),
		.ovf(ovf)
	);

	// --------------------------------
	// Result and destinations
	// --------------------------------
	always_comb
	begin
		res = (op == AID_OP_CLR_M) ? AID_ZERO : sum;
		working_register_d = (op_valid && wr_w) ? res : working_register;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			working_register <= AID_WREG_RST;
		else
			working_register <= working_register_d;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mem_we <= 1'b0;
			mem_wdata <= AID_ZERO;
		end
		else
		begin
			mem_we <= op_valid && to_mem;
			if (op_valid && to_mem)
				mem_wdata <= res;
		end
	end

	// --------------------------------
	// Flags
	// --------------------------------
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			result_null_flag <= AID_FLAG_RST;
			arith_out_bit <= AID_FLAG_RST;
			nibble_out_bit <= AID_FLAG_RST;
			signed_wrap_bit <= AID_FLAG_RST;
		end
		else if (op_valid && flags_upd)
		begin
			result_null_flag <= (sum == AID_ZERO);
			arith_out_bit <= is_sub ? ~cout : cout;
			nibble_out_bit <= is_sub ? ~hcout : hcout;
			signed_wrap_bit <= ovf;
		end
	end

	// --------------------------------
	// Checks
	// --------------------------------
	add_imm_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_ADD_WI |=> working_register == $past(working_register) + $past(imm))
		else $error("add immediate result wrong");
	sub_mem_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_SUB_MW |=> mem_we && mem_wdata == $past(mem_rdata) - $past(working_register))
		else $error("memory subtract result wrong");
	sub_borrow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_SUB_WM |=> arith_out_bit == ($past(mem_rdata) > $past(working_register)))
		else $error("borrow flag wrong");
	inc_mem_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_INC_M |=> mem_we && mem_wdata == $past(mem_rdata) + 8'h01)
		else $error("increment result wrong");
	dec_mem_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_DEC_M |=> mem_we && mem_wdata == $past(mem_rdata) - 8'h01)
		else $error("decrement result wrong");
	clr_flags_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_CLR_M |=> mem_we && mem_wdata == 8'h00 && $stable(arith_out_bit)
		&& $stable(result_null_flag) && $stable(nibble_out_bit) && $stable(signed_wrap_bit))
		else $error("clear changed flags");
	zero_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_ADD_WM |=> result_null_flag == (working_register == 8'h00))
		else $error("zero flag wrong");
	nib_carry_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_ADD_WI |=>
		nibble_out_bit == ({1'b0, $past(working_register[3:0])} + {1'b0, $past(imm[3:0])} > 5'h0F))
		else $error("nibble carry wrong");
	adc_w_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		op_valid && op == AID_OP_ADC_W |=>
		working_register == $past(working_register) + {7'h00, $past(arith_out_bit)})
		else $error("add carry result wrong");
endmodule : aid_datapath
`default_nettype wire

// file: include/aid_pkg.sv
// Purpose: Shared constants for the arithmetic instruction datapath
// Assumes: 8-bit data, one clock, active-low asynchronous reset
// Notes: Opcode codes are local to this block
package aid_pkg;

	localparam int AID_DATA_W = 8;
	localparam int AID_NIB_W = 4;
	localparam int AID_OP_W = 5;
	localparam logic [7:0] AID_WREG_RST = 8'h00;
	localparam logic AID_FLAG_RST = 1'b0;
	localparam logic [7:0] AID_ONE = 8'h01;
	localparam logic [7:0] AID_ZERO = 8'h00;

	// Operation codes presented on the op port
	localparam logic [4:0] AID_OP_NOP = 5'h00;
	localparam logic [4:0] AID_OP_ADD_WI = 5'h01;
	localparam logic [4:0] AID_OP_ADD_WM = 5'h02;
	localparam logic [4:0] AID_OP_ADD_MW = 5'h03;
	localparam logic [4:0] AID_OP_ADC_WM = 5'h04;
	localparam logic [4:0] AID_OP_ADC_MW = 5'h05;
	localparam logic [4:0] AID_OP_ADC_W = 5'h06;
	localparam logic [4:0] AID_OP_ADC_M = 5'h07;
	localparam logic [4:0] AID_OP_NADD_W = 5'h08;
	localparam logic [4:0] AID_OP_NADD_M = 5'h09;
	localparam logic [4:0] AID_OP_SUB_WI = 5'h0A;
	localparam logic [4:0] AID_OP_SUB_WM = 5'h0B;
	localparam logic [4:0] AID_OP_SUB_MW = 5'h0C;
	localparam logic [4:0] AID_OP_SBC_WM = 5'h0D;
	localparam logic [4:0] AID_OP_SBC_MW = 5'h0E;
	localparam logic [4:0] AID_OP_SBC_W = 5'h0F;
	localparam logic [4:0] AID_OP_SBC_M = 5'h10;
	localparam logic [4:0] AID_OP_INC_M = 5'h11;
	localparam logic [4:0] AID_OP_DEC_M = 5'h12;
	localparam logic [4:0] AID_OP_CLR_M = 5'h13;

endpackage : aid_pkg

// file: rtl/aid_adder.sv
// Purpose: 8-bit adder with carry, nibble carry and signed overflow
// Assumes: Subtraction is done by the caller inverting b and setting cin
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module aid_adder
#(
	parameter int W = 8
)
(
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	output logic [W-1:0] sum,
	output logic cout,
	output logic hcout,
	output logic ovf
);
	logic [W:0] full;
	logic [4:0] low;

	// --------------------------------
	// Sum and carries
	// --------------------------------
	always_comb
	begin
		full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		sum = full[W-1:0];
		cout = full[W];
		hcout = low[4];
		ovf = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
	end
endmodule : aid_adder
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the arithmetic instruction datapath
// Assumes: Outputs update on the edge that takes an op and are checked 1 ns after it
// Notes: A reference model in the bench tracks register and flags
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import aid_pkg::*;
	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic core_clk, reset_n, op_valid;
	logic [4:0] op;
	logic [7:0] imm, mem_rdata, working_register, mem_wdata;
	logic mem_we, result_null_flag, arith_out_bit, nibble_out_bit, signed_wrap_bit;
	int err_count, n_tests;
	logic [7:0] w_m;
	logic [7:0] d_m;
	logic z_m, c_m, h_m, v_m;
	aid_datapath u_dut (.core_clk(core_clk), .reset_n(reset_n), .op_valid(op_valid), .op(op), .imm(imm),
		.mem_rdata(mem_rdata), .working_register(working_register), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.result_null_flag(result_null_flag), .arith_out_bit(arith_out_bit), .nibble_out_bit(nibble_out_bit),
		.signed_wrap_bit(signed_wrap_bit));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task chk_all(input logic we, input logic [7:0] r);
		chk(working_register, w_m);
		chk({7'h00, mem_we}, {7'h00, we});
		if (we)
			d_m = r;
		chk(mem_wdata, d_m);
		chk({4'h0, result_null_flag, arith_out_bit, nibble_out_bit, signed_wrap_bit}, {4'h0, z_m, c_m, h_m, v_m});
	endtask : chk_all
	task rst(input int n);
		reset_n = 1'b0;
		op_valid = 1'b0;
		repeat (n) @(posedge core_clk);
		{w_m, z_m, c_m, h_m, v_m} = 12'h000;
		d_m = 8'h00;
		chk_all(1'b0, 8'h00);
		#1 reset_n = 1'b1;
	endtask : rst
	task exec(input logic [4:0] o, input logic [7:0] i, input logic [7:0] m);
		logic [7:0] a, b, bb, r;
		logic ci, sb, md, fl, ok;
		logic [8:0] s;
		logic [4:0] hs;
		a = w_m;
		b = m;
		ci = 1'b0;
		sb = 1'b0;
		md = 1'b0;
		fl = 1'b1;
		ok = 1'b1;
		case (o)
			AID_OP_ADD_WI: b = i;
			AID_OP_ADD_WM: ;
			AID_OP_ADD_MW: md = 1'b1;
			AID_OP_ADC_WM: ci = c_m;
			AID_OP_ADC_MW: {ci, md} = {c_m, 1'b1};
			AID_OP_ADC_W: {b, ci} = {8'h00, c_m};
			AID_OP_ADC_M: {a, b, ci, md} = {m, 8'h00, c_m, 1'b1};
			AID_OP_NADD_W: {a, b, sb} = {m, w_m, 1'b1};
			AID_OP_NADD_M: {sb, md} = 2'h3;
			AID_OP_SUB_WI: {b, sb} = {i, 1'b1};
			AID_OP_SUB_WM: sb = 1'b1;
			AID_OP_SUB_MW: {a, b, sb, md} = {m, w_m, 2'h3};
			AID_OP_SBC_WM: {sb, ci} = {1'b1, c_m};
			AID_OP_SBC_MW: {a, b, sb, ci, md} = {m, w_m, 1'b1, c_m, 1'b1};
			AID_OP_SBC_W: {b, sb, ci} = {8'h00, 1'b1, c_m};
			AID_OP_SBC_M: {a, b, sb, ci, md} = {m, 8'h00, 1'b1, c_m, 1'b1};
			AID_OP_INC_M: {a, b, md} = {m, AID_ONE, 1'b1};
			AID_OP_DEC_M: {a, b, sb, md} = {m, AID_ONE, 2'h3};
			AID_OP_CLR_M: {fl, md} = 2'h1;
			default: {fl, ok} = 2'h0;
		endcase
		bb = sb ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, ci ^ sb};
		hs = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci ^ sb};
		r = (o == AID_OP_CLR_M) ? AID_ZERO : s[7:0];
		op = o;
		imm = i;
		mem_rdata = m;
		op_valid = 1'b1;
		@(posedge core_clk);
		#1;
		if (fl)
			{z_m, c_m, h_m, v_m} = {r == 8'h00, s[8] ^ sb, hs[4] ^ sb, (a[7] == bb[7]) && (r[7] != a[7])};
		if (ok && !md)
			w_m = r;
		chk_all(md, r);
	endtask : exec
	task idle;
		op_valid = 1'b0;
		@(posedge core_clk);
		#1;
		chk_all(1'b0, 8'h00);
	endtask : idle
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_add;
		exec(AID_OP_ADD_WI, 8'h7F, 8'h00);
		exec(AID_OP_ADD_WI, 8'h01, 8'h00);
		exec(AID_OP_ADD_WM, 8'h00, 8'h80);
		exec(AID_OP_ADD_MW, 8'h00, 8'h0F);
		exec(AID_OP_ADD_WM, 8'h00, 8'h35);
		idle();
		$display("add test done");
	endtask : t_add
	task t_adc;
		exec(AID_OP_ADD_WI, 8'hFF, 8'h00);
		exec(AID_OP_ADC_WM, 8'h00, 8'h10);
		exec(AID_OP_ADC_MW, 8'h00, 8'hFE);
		exec(AID_OP_ADC_W, 8'h00, 8'h00);
		exec(AID_OP_SUB_WI, 8'hFF, 8'h00);
		exec(AID_OP_ADC_M, 8'h00, 8'hFF);
		exec(AID_OP_ADC_W, 8'h00, 8'h00);
		idle();
		$display("carry add test done");
	endtask : t_adc
	task t_sub;
		exec(AID_OP_SUB_WI, 8'h10, 8'h00);
		exec(AID_OP_SUB_WM, 8'h00, 8'h81);
		exec(AID_OP_SUB_MW, 8'h00, 8'h03);
		exec(AID_OP_NADD_W, 8'h00, 8'h05);
		exec(AID_OP_NADD_M, 8'h00, 8'h80);
		exec(AID_OP_SUB_WI, 8'h00, 8'h00);
		idle();
		$display("subtract test done");
	endtask : t_sub
	task t_sbc;
		exec(AID_OP_SUB_WI, 8'h20, 8'h00);
		exec(AID_OP_SBC_WM, 8'h00, 8'h01);
		exec(AID_OP_SBC_MW, 8'h00, 8'h10);
		exec(AID_OP_SBC_W, 8'h00, 8'h00);
		exec(AID_OP_SBC_M, 8'h00, 8'h00);
		exec(AID_OP_SBC_M, 8'h00, 8'h00);
		exec(AID_OP_SBC_W, 8'h00, 8'h00);
		idle();
		$display("borrow subtract test done");
	endtask : t_sbc
	task t_incdec;
		exec(AID_OP_INC_M, 8'h00, 8'hFF);
		exec(AID_OP_INC_M, 8'h00, 8'h7F);
		exec(AID_OP_CLR_M, 8'h00, 8'h5A);
		exec(AID_OP_DEC_M, 8'h00, 8'h00);
		exec(AID_OP_DEC_M, 8'h00, 8'h80);
		exec(AID_OP_DEC_M, 8'h00, 8'h01);
		exec(AID_OP_CLR_M, 8'h00, 8'hFF);
		exec(5'h1F, 8'h55, 8'h55);
		idle();
		$display("inc dec clear test done");
	endtask : t_incdec
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	initial
	begin
		#200000;
		err_count++;
		end_sim();
	end
	initial
	begin
		err_count = 0;
		n_tests = 0;
		op = AID_OP_NOP;
		imm = 8'h00;
		mem_rdata = 8'h00;
		rst(8);
		t_add();
		t_adc();
		t_sub();
		t_sbc();
		t_incdec();
		rst(2);
		t_add();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
